// *** shared/nand_host_regs.svh ***
// timing counts and opcode values for the host-side flash command driver
// assumes a 40 MHz system clock; included by the driver and the bench side
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH
`define CLK_PERIOD_NS      25
`define POWERUP_BUSY_US    5000
`define POWERUP_CYCLES     ((`POWERUP_BUSY_US * 1000) / `CLK_PERIOD_NS)
`define PROTECT_SETTLE_NS  100
`define PROTECT_CYCLES     ((`PROTECT_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_LOW_CYCLES  2
`define STROBE_HIGH_CYCLES 2
`define PAGE_BYTES         4352
`define SPARE_FIRST_COL    4096
`define PAGES_TOTAL        131072
`define BLOCKS_TOTAL       2048
`define OP_READ            8'h00
`define OP_READ_GO         8'h30
`define OP_COPY_READ_GO    8'h35
`define OP_PROT_STAT_GO    8'h34
`define OP_COPY_OUT_GO     8'h3a
`define OP_RAND_OUT        8'h05
`define OP_RAND_OUT_GO     8'he0
`define OP_CACHE_NEXT      8'h31
`define OP_CACHE_LAST      8'h3f
`define OP_PROGRAM         8'h80
`define OP_PROG_GO         8'h10
`define OP_CACHE_PROG_GO   8'h15
`define OP_COPY_PROGRAM    8'h85
`define OP_PAGE_COPY_PROG  8'h8c
`define OP_ERASE           8'h60
`define OP_ERASE_GO        8'hd0
`define OP_PROT_BOTH       8'h43
`define OP_PROT_ERASE      8'h42
`define OP_PROT_PROG       8'h41
`define OP_STATUS          8'h70
`define OP_PROT_STATUS     8'h74
`define OP_RESET           8'hff
`endif

// *** shared/nand_host_pkg.sv ***
// types for the host-side flash command driver
// assumes nand_host_regs.svh holds the numeric constants
package nand_host_pkg;
	// kind of one bus cycle handed to the driver
	typedef enum logic [1:0] {
		cyc_cmd  = 2'h0,
		cyc_addr = 2'h1,
		cyc_din  = 2'h2,
		cyc_dout = 2'h3
	} cycle_kind_t;

	typedef enum logic [4:0] {
		st_power = 5'h01,
		st_idle  = 5'h02,
		st_low   = 5'h04,
		st_high  = 5'h08,
		st_wait  = 5'h10
	} drv_state_t;
endpackage

// *** hdl/nand_host_driver.sv ***
// host-side pin driver for an asynchronous parallel NAND flash, byte mode
// assumes one request at a time from user logic on i_clock; pins go straight to the flash
// Operation
// - host drives pins while select and write strobe low; device latches on rise.
// - command latch high marks a command, address latch high an address.
// - host changes write protect only when idle, then waits the settle time.
// - after power on wait up to 5 ms busy; only status read allowed.
// - host should keep write protect low through power up and down.
// - read 00h..30h, program 80h..10h, cache program ends 15h.
// - erase is 60h, row address only, then D0h.
// - copy-back reads 00h..35h, then programs 85h, address, 10h.
// - random input 85h with column; random output 05h, column, E0h.
// - cache read continues with 31h, last page started by 3Fh.
// - page copy reads 00h..3Ah, programs 8Ch confirmed 15h or 10h.
// - protection prefix 43h, 42h or 41h then 80h..10h; status 00h..34h.
// - address column first then row, low bits first, unused high bits zero.
// - within a block program pages in ascending order.
`timescale 1ns/100ps
`include "nand_host_regs.svh"
module nand_host_driver
	import nand_host_pkg::*;
#(
	parameter int unsigned POWERUP_WAIT = `POWERUP_CYCLES
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	input  wire logic        i_req_valid,
	input  wire cycle_kind_t i_req_kind,
	input  wire logic [7:0]  i_req_data,
	input  wire logic        i_protect,
	output logic             o_req_ready,
	output logic             o_rsp_valid,
	output logic [7:0]       o_rsp_data,
	output logic             o_dev_busy,
	output logic             o_chip_sel_n,
	output logic             o_cmd_latch,
	output logic             o_addr_latch,
	output logic             o_write_strobe_n,
	output logic             o_read_strobe_n,
	output logic             o_write_protect_n,
	output logic [7:0]       o_io_out,
	output logic             o_io_oe_n,
	input  wire logic [7:0]  i_io_in,
	input  wire logic        i_ready_busy_n
);
	localparam logic [22:0] PROT_WAIT = 23'(`PROTECT_CYCLES);
	localparam logic [22:0] LOW_WAIT  = 23'(`STROBE_LOW_CYCLES - 1);
	localparam logic [22:0] HIGH_WAIT = 23'(`STROBE_HIGH_CYCLES - 1);

	// opcodes the device still takes while busy
	function automatic logic busy_ok(input logic [7:0] op);
		return (op == `OP_RESET) || (op == `OP_STATUS) || (op == `OP_PROT_STATUS);
	endfunction

	// program and erase openers, gated while protect is asserted
	function automatic logic writes_array(input logic [7:0] op);
		return (op == `OP_PROGRAM) || (op == `OP_COPY_PROGRAM) || (op == `OP_ERASE) ||
		       (op == `OP_PAGE_COPY_PROG) || (op == `OP_PROT_BOTH) ||
		       (op == `OP_PROT_ERASE) || (op == `OP_PROT_PROG);
	endfunction

	// reset release through two flops
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// pin inputs pass two flops; only the second stage is read
	// ready/busy starts as busy so o_dev_busy does not dip right after reset
	logic [8:0] pin_meta;
	logic [8:0] pin_sync;
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 9'h0ff;
			pin_sync <= 9'h0ff;
		end else begin
			pin_meta <= {i_ready_busy_n, i_io_in};
			pin_sync <= pin_meta;
		end
	end
	wire       rb_sync = pin_sync[8];
	wire [7:0] io_sync = pin_sync[7:0];

	drv_state_t  state, next_state;
	logic [22:0] count, next_count;
	cycle_kind_t kind, next_kind;
	logic [7:0]  data, next_data;
	logic        req_ready, next_req_ready;
	logic        rsp_valid, next_rsp_valid;
	logic [7:0]  rsp_data, next_rsp_data;
	logic        chip_sel_n, next_chip_sel_n;
	logic        cmd_latch, next_cmd_latch;
	logic        addr_latch, next_addr_latch;
	logic        wr_n, next_wr_n;
	logic        rd_n, next_rd_n;
	logic        wp_n, next_wp_n;
	logic        oe_n, next_oe_n;
	logic        settle_wait, next_settle_wait;

	// a request is refused while protect settles or while busy with a non-busy opcode;
	// read-out cycles still pass while busy, else status polling would stall
	wire refuse = settle_wait || (!rb_sync && ((i_req_kind == cyc_cmd) ?
	              !busy_ok(i_req_data) : (i_req_kind != cyc_dout)));

	// sequencer: one pin cycle per accepted request
	always_comb begin
		next_state       = state;
		next_count       = count;
		next_kind        = kind;
		next_data        = data;
		next_req_ready   = 1'b0;
		next_rsp_valid   = 1'b0;
		next_rsp_data    = rsp_data;
		next_chip_sel_n  = chip_sel_n;
		next_cmd_latch   = cmd_latch;
		next_addr_latch  = addr_latch;
		next_wr_n        = 1'b1;
		next_rd_n        = 1'b1;
		next_wp_n        = wp_n;
		next_oe_n        = oe_n;
		next_settle_wait = settle_wait;
		if (count != 23'h0)
			next_count = count - 23'h1;
		unique case (state)
			st_power: begin
				// protect held low and device left alone until init ends
				next_wp_n = 1'b0;
				if (count == 23'h0 && rb_sync) begin
					next_state     = st_idle;
					next_req_ready = 1'b1;
				end
			end
			st_idle: begin
				next_req_ready = 1'b1;
				if (settle_wait && count == 23'h0)
					next_settle_wait = 1'b0;
				if ((!i_protect) != wp_n && rb_sync && !settle_wait) begin
					// protect only moves while the device is idle, then settles
					next_wp_n        = !i_protect;
					next_settle_wait = 1'b1;
					next_count       = PROT_WAIT;
					next_req_ready   = 1'b0;
				end else if (i_req_valid && req_ready && !refuse) begin
					next_kind       = i_req_kind;
					next_data       = i_req_data;
					next_req_ready  = 1'b0;
					next_chip_sel_n = 1'b0;
					next_cmd_latch  = (i_req_kind == cyc_cmd);
					next_addr_latch = (i_req_kind == cyc_addr); // bytes pass as given
					next_oe_n       = (i_req_kind == cyc_dout);
					next_wr_n       = (i_req_kind == cyc_dout);
					next_rd_n       = (i_req_kind != cyc_dout);
					next_count      = LOW_WAIT;
					next_state      = st_low;
				end
			end
			st_low: begin
				// strobe stays low with data steady on the pins
				next_wr_n = (kind == cyc_dout);
				next_rd_n = (kind != cyc_dout);
				if (count == 23'h0) begin
					// rising edge latches in the device
					next_wr_n  = 1'b1;
					next_rd_n  = 1'b1;
					next_count = HIGH_WAIT;
					next_state = st_high;
				end
			end
			st_high: begin
				if (count == 23'h0) begin
					next_cmd_latch  = 1'b0;
					next_addr_latch = 1'b0;
					next_oe_n       = 1'b1;
					// the byte shown under the low strobe needs two sync stages to reach io_sync
					if (kind == cyc_dout) begin
						next_rsp_valid = 1'b1;
						next_rsp_data  = io_sync;
					end
					// confirms and one-cycle commands may start busy; let it show
					next_count      = 23'h3;
					next_state      = st_wait;
				end
			end
			st_wait: begin
				if (count == 23'h0) begin
					next_req_ready = 1'b1;
					next_state     = st_idle;
				end
			end
			default: begin
				next_state = st_idle;
			end
		endcase
		// array-writing openers are dropped while protected
		if (state == st_idle && next_state == st_low && i_req_kind == cyc_cmd &&
		    writes_array(i_req_data) && !wp_n) begin
			next_state      = st_idle;
			next_chip_sel_n = chip_sel_n;
			next_cmd_latch  = 1'b0;
			next_addr_latch = 1'b0;
			next_wr_n       = 1'b1;
			next_rd_n       = 1'b1;
			next_oe_n       = 1'b1;
			next_req_ready  = 1'b1;
			next_count      = count;
		end
	end

	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			state       <= st_power;
			count       <= POWERUP_WAIT[22:0];
			kind        <= cyc_cmd;
			data        <= 8'h00;
			req_ready   <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_data    <= 8'h00;
			chip_sel_n  <= 1'b1;
			cmd_latch   <= 1'b0;
			addr_latch  <= 1'b0;
			wr_n        <= 1'b1;
			rd_n        <= 1'b1;
			wp_n        <= 1'b0;
			oe_n        <= 1'b1;
			settle_wait <= 1'b0;
		end else begin
			state       <= next_state;
			count       <= next_count;
			kind        <= next_kind;
			data        <= next_data;
			req_ready   <= next_req_ready;
			rsp_valid   <= next_rsp_valid;
			rsp_data    <= next_rsp_data;
			chip_sel_n  <= next_chip_sel_n;
			cmd_latch   <= next_cmd_latch;
			addr_latch  <= next_addr_latch;
			wr_n        <= next_wr_n;
			rd_n        <= next_rd_n;
			wp_n        <= next_wp_n;
			oe_n        <= next_oe_n;
			settle_wait <= next_settle_wait;
		end
	end

	// busy flag registered from the synchronised pin
	logic dev_busy;
	always_ff @(posedge i_clock or negedge rst_n) begin
		if (!rst_n)
			dev_busy <= 1'b1;
		else
			dev_busy <= !rb_sync;
	end

	assign o_req_ready       = req_ready;
	assign o_rsp_valid       = rsp_valid;
	assign o_rsp_data        = rsp_data;
	assign o_dev_busy        = dev_busy;
	assign o_chip_sel_n      = chip_sel_n;
	assign o_cmd_latch       = cmd_latch;
	assign o_addr_latch      = addr_latch;
	assign o_write_strobe_n  = wr_n;
	assign o_read_strobe_n   = rd_n;
	assign o_write_protect_n = wp_n;
	assign o_io_out          = data;
	assign o_io_oe_n         = oe_n;

	chk_latch_exclusive: assert property (@(posedge i_clock) disable iff (!rst_n)
		!(cmd_latch && addr_latch)) else $error("both latch enables high");
	chk_strobe_select: assert property (@(posedge i_clock) disable iff (!rst_n)
		!wr_n |-> !chip_sel_n) else $error("write strobe low without select");
	chk_strobe_width: assert property (@(posedge i_clock) disable iff (!rst_n)
		$fell(wr_n) |=> !wr_n ##1 wr_n) else $error("write strobe width wrong");
	chk_latch_hold: assert property (@(posedge i_clock) disable iff (!rst_n)
		$rose(wr_n) && state == st_high |-> $stable(cmd_latch) && $stable(addr_latch))
		else $error("latch enable moved at strobe rise");
	chk_busy_gate: assert property (@(posedge i_clock) disable iff (!rst_n)
		$fell(wr_n) && cmd_latch && $past(!rb_sync) |-> busy_ok(data))
		else $error("non-busy command issued while busy");
	chk_protect_gate: assert property (@(posedge i_clock) disable iff (!rst_n)
		$fell(wr_n) && cmd_latch |-> !(writes_array(data) && !wp_n))
		else $error("array write opcode sent while protected");
	chk_protect_idle: assert property (@(posedge i_clock) disable iff (!rst_n)
		$changed(wp_n) && state != st_power |-> $past(state) == st_idle && $past(rb_sync))
		else $error("protect moved while not idle");
	chk_power_hold: assert property (@(posedge i_clock) disable iff (!rst_n)
		state == st_power |-> wr_n && chip_sel_n && !wp_n)
		else $error("pins moved during power-up wait");
endmodule

// *** dv/flash_model.sv ***
// behavioural flash device answering the host driver's pins
// assumes the bench resolves the io bus and pulls ready/busy high
`timescale 1ns/100ps
`include "nand_host_regs.svh"
module flash_model #(
	parameter int POWER_NS = 2000,
	parameter int OP_NS    = 1500
) (
	input  wire logic       i_chip_sel_n,
	input  wire logic       i_cmd_latch,
	input  wire logic       i_addr_latch,
	input  wire logic       i_write_strobe_n,
	input  wire logic       i_read_strobe_n,
	input  wire logic       i_write_protect_n,
	input  wire logic [7:0] i_io,
	output logic [7:0]      o_io,
	output logic            o_busy_low
);
	logic [7:0] page [`PAGE_BYTES]; // data plus spare columns
	logic [7:0] last_cmd = 8'h00;
	logic [7:0] setup    = 8'h00;
	logic [7:0] shown    = 8'h00;
	int         naddr    = 0;
	int         cmds     = 0;
	int         starts   = 0;
	int         col      = 0;
	// known fill so reads can be predicted; busy through initialisation
	initial begin
		for (int i = 0; i < `PAGE_BYTES; i++) begin
			page[i] = i[7:0] ^ 8'h5a;
		end
		o_busy_low = 1'b1;
		#POWER_NS o_busy_low = 1'b0;
	end
	// whole-page or whole-block array work, ready/busy pulled low meanwhile
	task automatic run_op();
		starts++;
		o_busy_low = 1'b1;
		#OP_NS o_busy_low = 1'b0;
	endtask
	// confirm opcode must follow its own setup
	function automatic logic matched(input logic [7:0] s, input logic [7:0] c);
		case (c)
			8'h30, 8'h35, 8'h3a, 8'h34: return s == 8'h00;
			8'h10, 8'h15: return s inside {8'h80, 8'h85, 8'h8c};
			8'hd0: return s == 8'h60;
			default: return 1'b0;
		endcase
	endfunction
	// values latch on the rising write strobe while selected
	always @(posedge i_write_strobe_n) begin
		if (!i_chip_sel_n && i_cmd_latch && (!o_busy_low || i_io inside {8'hff, 8'h70, 8'h74})) begin
			// a busy device drops all but reset and status reads
			cmds++;
			last_cmd = i_io;
			if (matched(setup, i_io) && (i_write_protect_n || !(i_io inside {8'h10, 8'h15, 8'hd0})))
			begin
				// two-cycle op starts on confirm; 10h, 15h and D0h confirms start nothing while protected
				fork
					run_op();
				join_none
			end
			setup = i_io;
			naddr = 0;
		end else if (!i_chip_sel_n && i_addr_latch && naddr < 5) begin
			// column low byte first, extra cycles ignored
			col = (naddr == 0) ? int'(i_io) : (naddr == 1) ? col + 256 * i_io[4:0] : col;
			naddr++;
		end else if (!i_chip_sel_n && !i_cmd_latch && !i_addr_latch) begin
			page[col % `PAGE_BYTES] = i_io;
			col++;
		end
	end
	// each falling read strobe shows the status or the next page byte
	always @(negedge i_read_strobe_n) begin
		if (!i_chip_sel_n) begin
			shown = (last_cmd == 8'h70) ? {1'b0, !o_busy_low, 6'h00} : page[col % `PAGE_BYTES];
			col = (last_cmd == 8'h70) ? col : col + 1;
		end
	end
	// released bus shows the inverse of the last byte so a stale sample is caught
	assign o_io = (!i_chip_sel_n && !i_read_strobe_n) ? shown : ~shown;
endmodule

// *** dv/testbench.sv ***
// self-checking bench: host driver against the behavioural flash device
// assumes the driver's hand-over timing; io and ready/busy resolved here
`timescale 1ns/100ps
`include "nand_host_regs.svh"
module testbench;
	import nand_host_pkg::*;
	logic        i_clock   = 1'b0;
	logic        i_rst_n   = 1'b0;
	logic        req_valid = 1'b0;
	cycle_kind_t req_kind  = cyc_cmd;
	logic [7:0]  req_data  = 8'h00;
	logic        protect   = 1'b0;
	logic        req_ready, rsp_valid, dev_busy, cs_n, cle, ale, we_n, re_n, wp_n, oe_n, busy_low;
	logic [7:0]  rsp_data, io_out, model_io;
	int          fail_count = 0;
	int          checked    = 0;
	int          c;
	initial begin
		forever #12.5 i_clock = ~i_clock;
	end
	nand_host_driver #(.POWERUP_WAIT(20)) DUT (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_req_valid(req_valid), .i_req_kind(req_kind), .i_req_data(req_data),
		.i_protect(protect), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid),
		.o_rsp_data(rsp_data), .o_dev_busy(dev_busy), .o_chip_sel_n(cs_n), .o_cmd_latch(cle),
		.o_addr_latch(ale), .o_write_strobe_n(we_n), .o_read_strobe_n(re_n),
		.o_write_protect_n(wp_n), .o_io_out(io_out), .o_io_oe_n(oe_n),
		.i_io_in(oe_n ? model_io : io_out), .i_ready_busy_n(!busy_low));
	flash_model model (.i_chip_sel_n(cs_n), .i_cmd_latch(cle), .i_addr_latch(ale),
		.i_write_strobe_n(we_n), .i_read_strobe_n(re_n), .i_write_protect_n(wp_n),
		.i_io(oe_n ? model_io : io_out), .o_io(model_io), .o_busy_low(busy_low));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
		#2;
	endtask
	// one request, held until its strobe falls, then left to finish its pin cycle
	task automatic send(input cycle_kind_t k, input logic [7:0] d);
		int n = 0;
		req_kind = k;
		req_data = d;
		req_valid = 1'b1;
		tick(1);
		// a refused or deferred request shows no strobe and stays pending
		while (we_n !== 1'b0 && re_n !== 1'b0 && n < 400) begin
			tick(1);
			n++;
		end
		req_valid = 1'b0;
		while ((we_n === 1'b0 || re_n === 1'b0) && n < 400) begin
			tick(1);
			n++;
		end
		if (n >= 400) check(8'h00, 8'h01);
	endtask
	task automatic read_byte(input logic [7:0] exp);
		int n = 0;
		send(cyc_dout, 8'h00);
		while (rsp_valid !== 1'b1 && n < 10) begin
			tick(1);
			n++;
		end
		check(rsp_data, exp);
	endtask
	// command that must never reach the pins
	task automatic refuse(input logic [7:0] d);
		c = model.cmds;
		req_data = d;
		req_kind = cyc_cmd;
		req_valid = 1'b1;
		tick(12);
		req_valid = 1'b0;
		tick(1);
		check(8'(model.cmds - c), 8'h00);
	endtask
	task automatic wait_busy(input logic exp);
		int n = 0;
		while (dev_busy !== exp && n < 200) begin
			tick(1);
			n++;
		end
		check({7'h00, dev_busy}, {7'h00, exp});
	endtask
	task automatic test_power();
		tick(6);
		check({cs_n, we_n, re_n, wp_n, oe_n, req_ready, dev_busy, 1'b0}, 8'hea);
		tick(6);
		i_rst_n = 1'b1;
		tick(40);
		check({6'h00, req_ready, dev_busy}, 8'h01);
		wait_busy(1'b0);
		$display("test power done");
	endtask
	logic [7:0] c_addr [5] = '{8'h05, 8'h01, 8'h02, 8'h00, 8'h00};
	task automatic test_read();
		c = model.cmds;
		send(cyc_cmd, `OP_STATUS);
		check(model.last_cmd, `OP_STATUS);
		check(8'(model.cmds - c), 8'h01);
		read_byte(8'h40);
		send(cyc_cmd, `OP_READ);
		foreach (c_addr[i]) send(cyc_addr, c_addr[i]);
		send(cyc_cmd, `OP_READ_GO);
		wait_busy(1'b1);
		refuse(`OP_READ);
		send(cyc_cmd, `OP_STATUS);
		read_byte(8'h00);
		wait_busy(1'b0);
		send(cyc_cmd, `OP_READ);
		read_byte(8'h5f);
		read_byte(8'h5c);
		// random data input lands one byte at the new column
		send(cyc_cmd, `OP_COPY_PROGRAM);
		send(cyc_addr, 8'h10);
		send(cyc_addr, 8'h00);
		send(cyc_din, 8'ha5);
		check(model.page[16], 8'ha5);
		$display("test read done");
	endtask
	task automatic test_protect();
		protect = 1'b1;
		tick(10);
		check({7'h00, wp_n}, 8'h00);
		refuse(`OP_PROGRAM);
		protect = 1'b0;
		tick(10);
		check({7'h00, wp_n}, 8'h01);
		c = model.starts;
		send(cyc_cmd, `OP_ERASE);
		repeat (3) send(cyc_addr, 8'h00);
		send(cyc_cmd, `OP_READ_GO);
		tick(10);
		check(8'(model.starts - c), 8'h00);
		send(cyc_cmd, `OP_ERASE);
		repeat (3) send(cyc_addr, 8'h00);
		send(cyc_cmd, `OP_ERASE_GO);
		wait_busy(1'b1);
		wait_busy(1'b0);
		$display("test protect done");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		test_power();
		test_read();
		test_protect();
		complete_run();
	end
	// cuts a hang short well past the expected few hundred cycles
	initial begin
		repeat (20000) @(posedge i_clock);
		fail_count++;
		complete_run();
	end
endmodule
